/* sdcd_pkg.sv */
// Shared constants and types of the command decoder.
// Assumes a single clock domain; pins arrive from outside it.
package sdcd_pkg;
  localparam int BANK_W = 3;
  localparam int ADDR_W = 16;
  localparam int SYNC_STAGES = 3;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam int COL_LO_W = 10;
  localparam int COL_HI_BIT = 11;
  localparam int COL_W = 11;
  localparam int BEATS_BL8 = 4;
  localparam int BEATS_BC4 = 2;
  localparam int SRX_WR_WAIT = 512;
  localparam logic [3:0] CNT_W = 4'hA;

  typedef enum logic [3:0] {
    SDCD_CMD_DESEL = 4'h0,
    SDCD_CMD_NOP = 4'h1,
    SDCD_CMD_MRS = 4'h2,
    SDCD_CMD_REF = 4'h3,
    SDCD_CMD_SRE = 4'h4,
    SDCD_CMD_SRX = 4'h5,
    SDCD_CMD_PRE = 4'h6,
    SDCD_CMD_PREA = 4'h7,
    SDCD_CMD_ACT = 4'h8,
    SDCD_CMD_WR = 4'h9,
    SDCD_CMD_RD = 4'hA,
    SDCD_CMD_PDE = 4'hB,
    SDCD_CMD_PDX = 4'hC,
    SDCD_CMD_ZQCL = 4'hD,
    SDCD_CMD_ZQCS = 4'hE,
    SDCD_CMD_ILL = 4'hF
  } sdcd_cmd_t;

  typedef enum logic [1:0] {
    SDCD_ST_IDLE = 2'h0,
    SDCD_ST_PD = 2'h1,
    SDCD_ST_SR = 2'h3
  } sdcd_state_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic odt;
  } sdcd_ctl_t;

  typedef struct packed {
    sdcd_cmd_t cmd;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic auto_pre;
    logic chop;
  } sdcd_dec_t;
endpackage

/* sdcd_sync.sv */
// Three-stage synchroniser with agreement filter, per bit.
// Assumes inputs asynchronous to clock.
`timescale 1ns/1ps
module sdcd_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  import sdcd_pkg::*;
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          s1_q[i] <= 1'b0;
          s2_q[i] <= 1'b0;
          s3_q[i] <= 1'b0;
          dout[i] <= 1'b0;
        end else if (ce) begin
          s1_q[i] <= din[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          if (s2_q[i] == s3_q[i]) begin
            dout[i] <= s3_q[i];
          end
        end
      end
    end
  endgenerate
endmodule

/* sdcd_decoder.sv */
// Command decoder: pins to decoded command, power state and burst tracking.
// Assumes a memory controller driving the pins; one clock, async low reset.
// Function
// - Decode from strobes and CKE at edge
// - Address widths follow configured part
// - Mode set: all strobes low, bank selects
// - Activate: bank plus row address
// - Write: column on A0-A9,A11, A10 low
// - On-the-fly write: A12 picks chop
// - Write A10 high auto-precharges bank
// - Read: column on A0-A9,A11, A10 low
// - On-the-fly read: A12 picks chop
// - Read A10 high auto-precharges bank
// - Bursts always complete; mode sets chop mode
// - No-operation leaves running work alone
// - Deselect behaves as no-operation
// - Valid pins defined, don't-care may float
// - No refresh while powered down
// - Self-refresh exit on CKE rising asynchronously
// - Termination input never affects decoding
// - Reset is asynchronous only
`timescale 1ns/1ps
module sdcd_decoder #(
  parameter int BANKS_W = sdcd_pkg::BANK_W,
  parameter int ROW_W = sdcd_pkg::ADDR_W,
  parameter int COLS_W = sdcd_pkg::COL_W,
  parameter bit OTF_DEFAULT = 1'b1
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  input wire sdcd_pkg::sdcd_ctl_t ctl_pin,
  input wire logic [sdcd_pkg::BANK_W-1:0] bank_pin,
  input wire logic [sdcd_pkg::ADDR_W-1:0] addr_pin,
  input wire logic otf_mode,
  output sdcd_pkg::sdcd_dec_t dec_q,
  output logic dec_valid_q,
  output logic burst_busy_q,
  output logic burst_is_wr_q,
  output logic auto_pre_fire_q,
  output logic [sdcd_pkg::BANK_W-1:0] auto_pre_bank_q,
  output logic [1:0] mode_reg_sel_q,
  output sdcd_pkg::sdcd_state_t pwr_state_q,
  output logic refresh_active_q,
  output logic odt_enable_q,
  output logic srx_pending_q
);
  import sdcd_pkg::*;

  localparam logic [ADDR_W-1:0] ROW_MASK = ADDR_W'((64'h1 << ROW_W) - 64'h1);
  localparam logic [BANK_W-1:0] BANK_MASK = BANK_W'((64'h1 << BANKS_W) - 64'h1);
  localparam logic [2:0] BL8_BEATS = 3'(BEATS_BL8);
  localparam logic [2:0] BC4_BEATS = 3'(BEATS_BC4);

  sdcd_ctl_t ctl_s;
  logic cke_prev_q;
  logic cke_async_q;
  sdcd_dec_t dec_d;
  logic [2:0] beats_q;
  logic bursts_ap_q;
  logic [BANK_W-1:0] burst_bank_q;
  logic otf_q;

  // Pins crossing into the clock domain
  sdcd_sync #(.W($bits(sdcd_ctl_t))) u_ctl_sync (
    .clock(clock),
    .resetn(resetn),
    .ce(ce),
    .din(ctl_pin),
    .dout(ctl_s)
  );

  // Address and bank delayed four stages, matching the strobe filter output
  logic [BANK_W-1:0] bank_s1_q, bank_s2_q, bank_s3_q, bank_s4_q;
  logic [ADDR_W-1:0] addr_s1_q, addr_s2_q, addr_s3_q, addr_s4_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bank_s1_q <= '0;
      bank_s2_q <= '0;
      bank_s3_q <= '0;
      bank_s4_q <= '0;
      addr_s1_q <= '0;
      addr_s2_q <= '0;
      addr_s3_q <= '0;
      addr_s4_q <= '0;
    end else if (ce) begin
      bank_s1_q <= bank_pin;
      bank_s2_q <= bank_s1_q;
      bank_s3_q <= bank_s2_q;
      bank_s4_q <= bank_s3_q;
      addr_s1_q <= addr_pin;
      addr_s2_q <= addr_s1_q;
      addr_s3_q <= addr_s2_q;
      addr_s4_q <= addr_s3_q;
    end
  end

  // Command decode from strobe levels at the edge
  always_comb begin
    logic [ADDR_W-1:0] col;
    col = '0;
    dec_d.cmd = SDCD_CMD_ILL;
    dec_d.bank = bank_s4_q & BANK_MASK;
    dec_d.addr = addr_s4_q & ROW_MASK;
    dec_d.auto_pre = addr_s4_q[AP_BIT];
    dec_d.chop = otf_q ? ~addr_s4_q[BC_BIT] : 1'b0;
    col[COL_LO_W-1:0] = addr_s4_q[COL_LO_W-1:0];
    col[COL_LO_W] = addr_s4_q[COL_HI_BIT];
    if (pwr_state_q == SDCD_ST_SR) begin
      dec_d.cmd = ctl_s.cke ? SDCD_CMD_SRX : SDCD_CMD_DESEL;
    end else if (pwr_state_q == SDCD_ST_PD) begin
      dec_d.cmd = ctl_s.cke ? SDCD_CMD_PDX : SDCD_CMD_DESEL;
    end else if (ctl_s.cs_n) begin
      dec_d.cmd = (cke_prev_q && !ctl_s.cke) ? SDCD_CMD_PDE : SDCD_CMD_DESEL;
    end else begin
      case ({ctl_s.ras_n, ctl_s.cas_n, ctl_s.we_n})
        3'h0: dec_d.cmd = (cke_prev_q && ctl_s.cke) ? SDCD_CMD_MRS : SDCD_CMD_ILL;
        3'h1: begin
          if (cke_prev_q && ctl_s.cke) begin
            dec_d.cmd = SDCD_CMD_REF;
          end else if (cke_prev_q) begin
            dec_d.cmd = burst_busy_q ? SDCD_CMD_ILL : SDCD_CMD_SRE;
          end
        end
        3'h2: dec_d.cmd = dec_d.auto_pre ? SDCD_CMD_PREA : SDCD_CMD_PRE;
        3'h3: dec_d.cmd = SDCD_CMD_ACT;
        3'h4: begin
          dec_d.cmd = SDCD_CMD_WR;
          dec_d.addr = col & ADDR_W'((64'h1 << COLS_W) - 64'h1);
        end
        3'h5: begin
          dec_d.cmd = SDCD_CMD_RD;
          dec_d.addr = col & ADDR_W'((64'h1 << COLS_W) - 64'h1);
        end
        3'h6: dec_d.cmd = dec_d.auto_pre ? SDCD_CMD_ZQCL : SDCD_CMD_ZQCS;
        default: dec_d.cmd = (cke_prev_q && !ctl_s.cke) ? SDCD_CMD_PDE : SDCD_CMD_NOP;
      endcase
    end
    if (!cke_prev_q && pwr_state_q == SDCD_ST_IDLE) begin
      dec_d.cmd = SDCD_CMD_DESEL;
    end
  end

  // Previous clock enable level
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cke_prev_q <= 1'b1;
    end else if (ce) begin
      cke_prev_q <= ctl_s.cke;
    end
  end

  // Burst mode choice set through mode register 0 writes
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      otf_q <= OTF_DEFAULT;
    end else if (ce && dec_d.cmd == SDCD_CMD_MRS && dec_d.bank == '0) begin
      otf_q <= otf_mode;
    end
  end

  // Decoded command register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dec_q <= '0;
      dec_valid_q <= 1'b0;
      mode_reg_sel_q <= '0;
    end else if (ce) begin
      dec_q <= dec_d;
      dec_valid_q <= dec_d.cmd != SDCD_CMD_DESEL && dec_d.cmd != SDCD_CMD_NOP;
      if (dec_d.cmd == SDCD_CMD_MRS) begin
        mode_reg_sel_q <= dec_d.bank[1:0];
      end
    end
  end

  // Burst tracking: runs out regardless of later commands
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      beats_q <= '0;
      burst_busy_q <= 1'b0;
      burst_is_wr_q <= 1'b0;
      bursts_ap_q <= 1'b0;
      burst_bank_q <= '0;
      auto_pre_fire_q <= 1'b0;
      auto_pre_bank_q <= '0;
    end else if (ce) begin
      auto_pre_fire_q <= 1'b0;
      if (beats_q != '0) begin
        beats_q <= beats_q - 3'h1;
        if (beats_q == 3'h1) begin
          burst_busy_q <= 1'b0;
          auto_pre_fire_q <= bursts_ap_q;
          auto_pre_bank_q <= burst_bank_q;
        end
      end else if (dec_d.cmd == SDCD_CMD_WR || dec_d.cmd == SDCD_CMD_RD) begin
        beats_q <= dec_d.chop ? BC4_BEATS : BL8_BEATS;
        burst_busy_q <= 1'b1;
        burst_is_wr_q <= dec_d.cmd == SDCD_CMD_WR;
        bursts_ap_q <= dec_d.auto_pre;
        burst_bank_q <= dec_d.bank;
      end
    end
  end

  // Power state tracking
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pwr_state_q <= SDCD_ST_IDLE;
      refresh_active_q <= 1'b0;
    end else if (ce) begin
      refresh_active_q <= 1'b0;
      case (pwr_state_q)
        SDCD_ST_IDLE: begin
          if (dec_d.cmd == SDCD_CMD_SRE) begin
            pwr_state_q <= SDCD_ST_SR;
          end else if (dec_d.cmd == SDCD_CMD_PDE) begin
            pwr_state_q <= SDCD_ST_PD;
          end
          refresh_active_q <= dec_d.cmd == SDCD_CMD_REF || dec_d.cmd == SDCD_CMD_SRE;
        end
        SDCD_ST_PD: begin
          if (dec_d.cmd == SDCD_CMD_PDX) begin
            pwr_state_q <= SDCD_ST_IDLE;
          end
        end
        SDCD_ST_SR: begin
          refresh_active_q <= 1'b1;
          if (srx_pending_q) begin
            pwr_state_q <= SDCD_ST_IDLE;
            refresh_active_q <= 1'b0;
          end
        end
        default: pwr_state_q <= SDCD_ST_IDLE;
      endcase
    end
  end

  // Raw exit request captured without waiting for the synchroniser
  always_ff @(posedge ctl_pin.cke or negedge resetn) begin
    if (!resetn) begin
      cke_async_q <= 1'b0;
    end else begin
      cke_async_q <= ~cke_async_q;
    end
  end

  logic tog_s1_q, tog_s2_q, tog_s3_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
      srx_pending_q <= 1'b0;
    end else if (ce) begin
      tog_s1_q <= cke_async_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
      srx_pending_q <= pwr_state_q == SDCD_ST_SR && (tog_s2_q != tog_s3_q || ctl_s.cke);
    end
  end

  // Termination honoured only outside self-refresh
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      odt_enable_q <= 1'b0;
    end else if (ce) begin
      odt_enable_q <= ctl_s.odt && pwr_state_q != SDCD_ST_SR;
    end
  end
endmodule

/* sdcd_decoder_monitor.sv */
// Checker of the decoder's burst, precharge, mode and power outputs.
// Assumes it is bound to sdcd_decoder; one clock, async low reset.
`timescale 1ns/1ps
module sdcd_decoder_monitor (
  input wire logic clock,
  input wire logic resetn,
  input wire sdcd_pkg::sdcd_dec_t dec_q,
  input wire logic dec_valid_q,
  input wire logic burst_busy_q,
  input wire logic burst_is_wr_q,
  input wire logic auto_pre_fire_q,
  input wire logic [1:0] mode_reg_sel_q,
  input wire sdcd_pkg::sdcd_state_t pwr_state_q,
  input wire logic refresh_active_q,
  input wire logic odt_enable_q
);
  import sdcd_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  full_burst_a: assert property ($rose(burst_busy_q) && !dec_q.chop |-> burst_busy_q [*4] ##1 !burst_busy_q)
    else $error("full burst length wrong");
  chop_burst_a: assert property ($rose(burst_busy_q) && dec_q.chop |-> burst_busy_q [*2] ##1 !burst_busy_q)
    else $error("chopped burst length wrong");
  burst_cause_a: assert property ($rose(burst_busy_q) |-> dec_q.cmd inside {SDCD_CMD_RD, SDCD_CMD_WR})
    else $error("burst without read or write");
  burst_kind_a: assert property ($rose(burst_busy_q) |-> burst_is_wr_q == (dec_q.cmd == SDCD_CMD_WR))
    else $error("burst type wrong");
  burst_hold_a: assert property (burst_busy_q && $past(burst_busy_q) |-> $stable(burst_is_wr_q))
    else $error("burst interrupted");
  fire_end_a: assert property (auto_pre_fire_q |-> !burst_busy_q && $past(burst_busy_q) ##1 !auto_pre_fire_q)
    else $error("auto precharge not at burst end");
  valid_cmd_a: assert property (dec_valid_q |-> !(dec_q.cmd inside {SDCD_CMD_NOP, SDCD_CMD_DESEL}))
    else $error("idle command flagged valid");
  mode_sel_a: assert property (dec_valid_q && dec_q.cmd == SDCD_CMD_MRS |-> ##1 mode_reg_sel_q == $past(dec_q.bank[1:0]))
    else $error("mode register select wrong");
  sr_odt_a: assert property (pwr_state_q == SDCD_ST_SR && $past(pwr_state_q) == SDCD_ST_SR |-> !odt_enable_q)
    else $error("termination on in self-refresh");
  pd_noref_a: assert property (pwr_state_q == SDCD_ST_PD |-> !refresh_active_q)
    else $error("refresh while powered down");
endmodule
bind sdcd_decoder sdcd_decoder_monitor sdcd_decoder_monitor_i (.clock, .resetn, .dec_q, .dec_valid_q, .burst_busy_q,
  .burst_is_wr_q, .auto_pre_fire_q, .mode_reg_sel_q, .pwr_state_q, .refresh_active_q, .odt_enable_q);

/* sdcd_ctrl_model.sv */
// Memory controller model driving the command pins.
// Assumes the testbench calls put; pins change 1 ns after an edge.
`timescale 1ns/1ps
module sdcd_ctrl_model (
  input wire logic clock,
  output sdcd_pkg::sdcd_ctl_t ctl,
  output logic [sdcd_pkg::BANK_W-1:0] bank,
  output logic [sdcd_pkg::ADDR_W-1:0] addr
);
  import sdcd_pkg::*;
  int cyc = 0;
  int srx_at = -1000;
  initial begin
    ctl = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    bank = '0;
    addr = '0;
  end
  always @(posedge clock) cyc <= cyc + 1;
  // Strobes {cs,ras,cas,we}; held over two edges
  task automatic put(input logic [3:0] c, input logic ck, input logic [2:0] b, input logic [15:0] a);
    if (c == 4'h4) while (cyc - srx_at < SRX_WR_WAIT) @(posedge clock);
    @(posedge clock);
    #1;
    if (!ctl.cke && ck) srx_at = cyc;
    {ctl.cs_n, ctl.ras_n, ctl.cas_n, ctl.we_n} = c;
    ctl.cke = ck;
    ctl.odt = a[0];
    bank = c[3] ? ~bank : b;
    addr = c[3] ? ~addr : a;
    @(posedge clock);
    #1;
  endtask
endmodule

/* sdcd_decoder_tb_top.sv */
// Testbench of the command decoder with a controller model.
// Assumes the checker is bound in; 4 ns clock.
`timescale 1ns/1ps
module sdcd_decoder_tb_top;
  import sdcd_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  sdcd_ctl_t ctl;
  logic [BANK_W-1:0] bank;
  logic [ADDR_W-1:0] addr;
  sdcd_dec_t dec_q;
  logic dec_valid_q, burst_busy_q, burst_is_wr_q, auto_pre_fire_q, refresh_active_q;
  logic odt_enable_q, srx_pending_q;
  logic [BANK_W-1:0] auto_pre_bank_q;
  logic [1:0] mode_reg_sel_q;
  sdcd_state_t pwr_state_q;
  int error_cnt = 0;
  int cmp_count = 0;
  always #2 clock = ~clock;
  sdcd_ctrl_model sdcd_ctrl_model_i (.clock, .ctl, .bank, .addr);
  sdcd_decoder sdcd_decoder_i (.clock, .resetn, .ce(1'b1), .ctl_pin(ctl), .bank_pin(bank), .addr_pin(addr),
    .otf_mode(1'b1), .dec_q, .dec_valid_q, .burst_busy_q, .burst_is_wr_q, .auto_pre_fire_q, .auto_pre_bank_q,
    .mode_reg_sel_q, .pwr_state_q, .refresh_active_q, .odt_enable_q, .srx_pending_q);
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic await(input logic want_valid, input sdcd_state_t s);
    int n;
    n = 0;
    while ((want_valid ? dec_valid_q !== 1'b1 : pwr_state_q !== s) && n < 16) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n == 16) begin
      chk("wait", 16'h1, 16'h0);
      conclude();
    end
  endtask
  task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a, input sdcd_cmd_t e,
    input logic ap, input logic ch);
    sdcd_ctrl_model_i.put(c, 1'b1, b, a);
    await(1'b1, SDCD_ST_IDLE);
    chk("cmd", 16'(e), 16'(dec_q.cmd));
    chk("bank", 16'(b), 16'(dec_q.bank));
    chk("odt", 16'(a[0]), 16'(odt_enable_q));
    if (c[3:1] == 3'b010) begin
      chk("auto_pre", 16'(ap), 16'(dec_q.auto_pre));
      chk("chop", 16'(ch), 16'(dec_q.chop));
    end
    sdcd_ctrl_model_i.put(4'h7, 1'b1, 3'h0, 16'h0);
    sdcd_ctrl_model_i.put(4'h7, 1'b1, 3'h0, 16'h0);
  endtask
  task automatic t_decode;
    cmd(4'h0, 3'h0, 16'h0000, SDCD_CMD_MRS, 1'b0, 1'b0);
    cmd(4'h0, 3'h2, 16'h0000, SDCD_CMD_MRS, 1'b0, 1'b0);
    chk("mode_sel", 16'h2, 16'(mode_reg_sel_q));
    cmd(4'h3, 3'h7, 16'hBEEF, SDCD_CMD_ACT, 1'b0, 1'b0);
    cmd(4'h2, 3'h5, 16'h0000, SDCD_CMD_PRE, 1'b0, 1'b0);
    cmd(4'h2, 3'h5, 16'h0400, SDCD_CMD_PREA, 1'b0, 1'b0);
    cmd(4'h6, 3'h0, 16'h0400, SDCD_CMD_ZQCL, 1'b0, 1'b0);
    cmd(4'h6, 3'h0, 16'h0000, SDCD_CMD_ZQCS, 1'b0, 1'b0);
    cmd(4'h1, 3'h0, 16'h0000, SDCD_CMD_REF, 1'b0, 1'b0);
    cmd(4'h5, 3'h1, 16'h0020, SDCD_CMD_RD, 1'b0, 1'b1);
    cmd(4'h5, 3'h6, 16'h1400, SDCD_CMD_RD, 1'b1, 1'b0);
    cmd(4'h4, 3'h0, 16'h0007, SDCD_CMD_WR, 1'b0, 1'b1);
    $display("test decode done");
  endtask
  task automatic t_burst;
    int b, f;
    b = 0;
    f = 0;
    sdcd_ctrl_model_i.put(4'h4, 1'b1, 3'h3, 16'h1405);
    sdcd_ctrl_model_i.put(4'h5, 1'b1, 3'h1, 16'h0020);
    sdcd_ctrl_model_i.put(4'h8, 1'b1, 3'h0, 16'h0);
    if (burst_busy_q === 1'b1) b++;
    repeat (16) begin
      @(posedge clock);
      #1;
      if (burst_busy_q === 1'b1) b++;
      if (auto_pre_fire_q === 1'b1) f++;
      if (auto_pre_fire_q === 1'b1) chk("ap_bank", 16'h3, 16'(auto_pre_bank_q));
    end
    chk("wr_beats", 16'(BEATS_BL8), 16'(b));
    chk("ap_fires", 16'h1, 16'(f));
    $display("test burst done");
  endtask
  task automatic t_power;
    sdcd_ctrl_model_i.put(4'h7, 1'b0, 3'h0, 16'h0);
    await(1'b0, SDCD_ST_PD);
    chk("pwr_pd", 16'(SDCD_ST_PD), 16'(pwr_state_q));
    sdcd_ctrl_model_i.put(4'h7, 1'b1, 3'h0, 16'h0);
    await(1'b0, SDCD_ST_IDLE);
    sdcd_ctrl_model_i.put(4'h1, 1'b0, 3'h0, 16'h0);
    await(1'b0, SDCD_ST_SR);
    chk("sr_refresh", 16'h1, 16'(refresh_active_q));
    chk("srx_early", 16'h0, 16'(srx_pending_q));
    chk("sr_odt", 16'h0, 16'(odt_enable_q));
    sdcd_ctrl_model_i.put(4'h7, 1'b1, 3'h0, 16'h0);
    await(1'b0, SDCD_ST_IDLE);
    chk("pwr_idle", 16'(SDCD_ST_IDLE), 16'(pwr_state_q));
    cmd(4'h4, 3'h2, 16'h1000, SDCD_CMD_WR, 1'b0, 1'b0);
    $display("test power done");
  endtask
  initial begin
    repeat (20) @(posedge clock);
    #1;
    resetn = 1'b1;
    t_decode();
    t_burst();
    t_power();
    conclude();
  end
endmodule
